/* verilog/dac_load_pkg.sv */
package dac_load_pkg;
  // Word layout
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int SEL_BIT = 12;
  localparam int CODE_MSB = 11;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;

  // Reset values of shift register, latches and outputs
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;

  // Pin synchroniser
  localparam int SYNC_STAGES = 3;
  localparam int PIN_COUNT = 5;
  localparam int PIN_SCLK = 0;
  localparam int PIN_FRAME = 1;
  localparam int PIN_SDIN = 2;
  localparam int PIN_FMT = 3;
  localparam int PIN_LOAD = 4;
  // Idle levels: frame and load strobe high, clock low
  localparam logic [4:0] PIN_RESET = 5'h12;

  // Word reception phase
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SHIFT,
    PH_FULL
  } phase_t;
endpackage : dac_load_pkg

/* verilog/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Raw pins and filtered levels
  input wire logic [W-1:0] i_pins,
  output logic [W-1:0] o_pins
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // Stage one feeds only stage two; a level counts once stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.stable[i] = st_r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_pins = st_r.stable;
endmodule : pin_sync

/* verilog/dual_dac_serial_load_port.sv */
`timescale 1ns/100ps
module dual_dac_serial_load_port (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Serial link from the host
  input wire logic i_sclk,
  input wire logic i_sdin,
  input wire logic i_frame_n,
  // Load strobe and code format strap
  input wire logic i_load_outputs_n,
  input wire logic i_code_format_select,
  // Input latches
  output logic [dac_load_pkg::CODE_BITS-1:0] o_latch_a,
  output logic [dac_load_pkg::CODE_BITS-1:0] o_latch_b,
  // Output levels, offset binary
  output logic [dac_load_pkg::CODE_BITS-1:0] o_out_a,
  output logic [dac_load_pkg::CODE_BITS-1:0] o_out_b
);
  import dac_load_pkg::*;

  typedef struct packed {
    phase_t phase;
    logic sclk_q;
    logic load_q;
    logic [3:0] bit_cnt;
    logic [WORD_BITS-1:0] shreg;
    logic [CODE_BITS-1:0] latch_a;
    logic [CODE_BITS-1:0] latch_b;
    logic [CODE_BITS-1:0] out_a;
    logic [CODE_BITS-1:0] out_b;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [PIN_COUNT-1:0] pins_s;
  logic sclk_s;
  logic frame_s;
  logic sdin_s;
  logic fmt_s;
  logic load_s;
  logic sclk_fall;
  logic load_fall;
  logic shifting;
  logic commit;
  logic [WORD_BITS-1:0] word;

  // Converts a received code to an offset binary level for the output
  function automatic logic [CODE_BITS-1:0] to_level(input logic [CODE_BITS-1:0] code, input logic fmt);
    logic [CODE_BITS-1:0] lvl;
    lvl = code;
    lvl[CODE_MSB] = code[CODE_MSB] ^ fmt;
    return lvl;
  endfunction : to_level

  // All pins pass the three-stage filter together, keeping data aligned with the clock
  pin_sync #(
    .W(PIN_COUNT),
    .RESET_VAL(PIN_RESET)
  ) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_pins({i_load_outputs_n, i_code_format_select, i_sdin, i_frame_n, i_sclk}),
    .o_pins(pins_s)
  );

  // Filtered pin levels
  assign sclk_s = pins_s[PIN_SCLK];
  assign frame_s = pins_s[PIN_FRAME];
  assign sdin_s = pins_s[PIN_SDIN];
  assign fmt_s = pins_s[PIN_FMT];
  assign load_s = pins_s[PIN_LOAD];

  // Edge detection on the filtered levels
  assign sclk_fall = st_r.sclk_q & ~sclk_s;
  assign load_fall = st_r.load_q & ~load_s;
  assign shifting = ~frame_s & (st_r.phase != PH_FULL) & sclk_fall;
  assign word = {st_r.shreg[WORD_BITS-2:0], sdin_s};
  assign commit = shifting & (st_r.bit_cnt == LAST_BIT);

  // Next state: reception, latching and output update
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_q = sclk_s;
    st_nxt.load_q = load_s;
    if (frame_s) begin
      // Extra clocks beyond a word are dropped until the frame is raised again
      st_nxt.phase = PH_IDLE;
      st_nxt.bit_cnt = BIT_CNT_RESET;
    end else begin
      unique case (st_r.phase)
        PH_IDLE, PH_SHIFT: begin
          st_nxt.phase = PH_SHIFT;
          if (shifting) begin
            st_nxt.shreg = word;
            st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
          end
          if (commit) begin
            st_nxt.phase = PH_FULL;
            if (word[SEL_BIT]) begin
              st_nxt.latch_b = word[CODE_BITS-1:0];
            end else begin
              st_nxt.latch_a = word[CODE_BITS-1:0];
            end
            if (!load_s) begin
              if (word[SEL_BIT]) begin
                st_nxt.out_b = to_level(word[CODE_BITS-1:0], fmt_s);
              end else begin
                st_nxt.out_a = to_level(word[CODE_BITS-1:0], fmt_s);
              end
            end
          end
        end
        PH_FULL: begin
          st_nxt.phase = PH_FULL;
        end
      endcase
    end
    // both outputs on strobe fall; the addressed one also at word end while strobe low
    if (load_fall) begin
      st_nxt.out_a = to_level(st_nxt.latch_a, fmt_s);
      st_nxt.out_b = to_level(st_nxt.latch_b, fmt_s);
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '{PH_IDLE, 1'h0, 1'h1, BIT_CNT_RESET, SHIFT_RESET, CODE_RESET, CODE_RESET, CODE_RESET, CODE_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_latch_a = st_r.latch_a;
  assign o_latch_b = st_r.latch_b;
  assign o_out_a = st_r.out_a;
  assign o_out_b = st_r.out_b;

  // Checks on the block's own behaviour
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_word_end;
    commit;
  endsequence

  sequence s_strobe_fall;
    load_fall;
  endsequence

  property p_frame_gate;
    frame_s |=> (st_r.phase == PH_IDLE) && (st_r.bit_cnt == BIT_CNT_RESET) && $stable(st_r.shreg);
  endproperty
  a_frame_gate: assert property (p_frame_gate) else $error("shift register moved with frame high");

  property p_capture;
    shifting |=> (st_r.shreg[0] == $past(sdin_s)) && (st_r.shreg[WORD_BITS-1:1] == $past(st_r.shreg[WORD_BITS-2:0]));
  endproperty
  a_capture: assert property (p_capture) else $error("data bit not captured on falling clock");

  property p_route_a;
    s_word_end and !word[SEL_BIT] |=> (st_r.latch_a == $past(word[CODE_BITS-1:0])) && $stable(st_r.latch_b);
  endproperty
  a_route_a: assert property (p_route_a) else $error("select zero did not load latch A");

  property p_route_b;
    s_word_end and word[SEL_BIT] |=> (st_r.latch_b == $past(word[CODE_BITS-1:0])) && $stable(st_r.latch_a);
  endproperty
  a_route_b: assert property (p_route_b) else $error("select one did not load latch B");

  property p_sixteen;
    s_word_end |-> (st_r.phase == PH_SHIFT) && (st_r.bit_cnt == LAST_BIT);
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("word closed on the wrong clock edge");

  property p_full_waits;
    (st_r.phase == PH_FULL) && !frame_s |=> (st_r.phase == PH_FULL) && $stable(st_r.shreg);
  endproperty
  a_full_waits: assert property (p_full_waits) else $error("extra clocks entered a full word");

  property p_simultaneous;
    s_strobe_fall |=> (st_r.out_a == to_level(st_r.latch_a, $past(fmt_s))) &&
      (st_r.out_b == to_level(st_r.latch_b, $past(fmt_s)));
  endproperty
  a_simultaneous: assert property (p_simultaneous) else $error("strobe fall did not update both outputs");

  property p_hold;
    load_s |=> $stable(st_r.out_a) && $stable(st_r.out_b);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed while load strobe high");

  property p_auto;
    s_word_end and !load_s and !word[SEL_BIT] |=> st_r.out_a == to_level($past(word[CODE_BITS-1:0]), $past(fmt_s));
  endproperty
  a_auto: assert property (p_auto) else $error("automatic update missed on sixteenth edge");

  property p_offset_binary;
    s_strobe_fall and !fmt_s |=> st_r.out_a == st_r.latch_a;
  endproperty
  a_offset_binary: assert property (p_offset_binary) else $error("offset binary code altered");
endmodule : dual_dac_serial_load_port

/* test/host_model.sv */
`timescale 1ns/100ps
module host_model (
  // Bench clock
  input wire logic i_ref_clk,
  // Serial link to the device
  output logic o_sclk,
  output logic o_sdin,
  output logic o_frame_n
);
  // Idle link: clock low, frame high
  initial begin
    o_sclk = 1'h0;
    o_sdin = 1'h0;
    o_frame_n = 1'h1;
  end
  // Changes land on falling reference edges
  task automatic tick(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : tick
  // active-low frame
  // Released data shows its inverse, never a stale bit
  task automatic frame(input logic lvl);
    o_frame_n = lvl;
    if (lvl) begin
      o_sdin = ~o_sdin;
    end
    tick(4);
  endtask : frame
  // MSB first, fall sampled
  // Clock rests low after each burst; the task drives no frame itself
  task automatic shift(input logic [15:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'h1;
      o_sdin = w[15-i];
      tick(4);
      o_sclk = 1'h0;
      tick(4);
    end
  endtask : shift
  // One whole word under its own frame
  task automatic word(input logic [15:0] w);
    frame(1'h0);
    shift(w, 16);
    frame(1'h1);
  endtask : word
endmodule : host_model

/* test/test_dual_dac_serial_load_port.sv */
`timescale 1ns/100ps
module test_dual_dac_serial_load_port;
  import dac_load_pkg::*;
  logic i_ref_clk;
  logic i_reset;
  logic i_load_outputs_n;
  logic i_code_format_select;
  logic sclk;
  logic sdin;
  logic frame_n;
  logic [CODE_BITS-1:0] o_latch_a;
  logic [CODE_BITS-1:0] o_latch_b;
  logic [CODE_BITS-1:0] o_out_a;
  logic [CODE_BITS-1:0] o_out_b;
  int error_cnt;
  int n_checks;
  int cycles;

  // Every pin is a live net from the host model or the bench
  dual_dac_serial_load_port u_dual_dac_serial_load_port (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_sclk(sclk),
    .i_sdin(sdin),
    .i_frame_n(frame_n),
    .i_load_outputs_n(i_load_outputs_n),
    .i_code_format_select(i_code_format_select),
    .o_latch_a(o_latch_a),
    .o_latch_b(o_latch_b),
    .o_out_a(o_out_a),
    .o_out_b(o_out_b)
  );
  host_model u_host_model (
    .i_ref_clk(i_ref_clk),
    .o_sclk(sclk),
    .o_sdin(sdin),
    .o_frame_n(frame_n)
  );

  // Reference clock, 20 ns
  initial begin
    i_ref_clk = 1'h0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // Hang guard, the tests need well under 2000 cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      conclude();
    end
  end

  // Strobe low long enough for the pin filter
  task automatic pulse_load();
    i_load_outputs_n = 1'h0;
    u_host_model.tick(6);
    i_load_outputs_n = 1'h1;
    u_host_model.tick(6);
  endtask : pulse_load

  task automatic t_both();
    u_host_model.word({3'h7, 1'h0, 12'hA5C});
    u_host_model.word({3'h0, 1'h1, 12'h3E1});
    check(o_latch_a, 12'hA5C, "latch a");
    check(o_latch_b, 12'h3E1, "latch b");
    check(o_out_a, 12'h000, "out a held");
    check(o_out_b, 12'h000, "out b held");
    pulse_load();
    check(o_out_a, 12'hA5C, "out a");
    check(o_out_b, 12'h3E1, "out b");
    $display("test both_channels done");
  endtask : t_both

  task automatic t_bytes();
    u_host_model.frame(1'h0);
    u_host_model.shift(16'hB87F, 8);
    u_host_model.tick(12);
    u_host_model.shift(16'h7F00, 8);
    u_host_model.frame(1'h1);
    check(o_latch_b, 12'h87F, "byte pair");
    check(o_out_b, 12'h3E1, "out b held");
    $display("test byte_pair done");
  endtask : t_bytes

  task automatic t_abort();
    u_host_model.shift(16'h0FFF, 16);
    check(o_latch_a, 12'hA5C, "no frame");
    u_host_model.frame(1'h0);
    u_host_model.shift(16'h1FFF, 10);
    u_host_model.frame(1'h1);
    check(o_latch_b, 12'h87F, "partial");
    u_host_model.word(16'h0123);
    check(o_latch_a, 12'h123, "after abort");
    $display("test abort done");
  endtask : t_abort

  task automatic t_auto();
    i_code_format_select = 1'h1;
    u_host_model.tick(6);
    i_load_outputs_n = 1'h0;
    u_host_model.tick(6);
    check(o_out_a, 12'h923, "twos a");
    check(o_out_b, 12'h07F, "twos b");
    u_host_model.word(16'h07FF);
    check(o_out_a, 12'hFFF, "auto a");
    check(o_out_b, 12'h07F, "auto b held");
    i_code_format_select = 1'h0;
    u_host_model.tick(6);
    u_host_model.word(16'h1456);
    check(o_out_b, 12'h456, "auto b");
    check(o_out_a, 12'hFFF, "auto a held");
    $display("test auto_update done");
  endtask : t_auto

  // Reset for 3 cycles, then the scenarios in turn
  initial begin
    i_reset = 1'h1;
    i_load_outputs_n = 1'h1;
    i_code_format_select = 1'h0;
    u_host_model.tick(3);
    i_reset = 1'h0;
    u_host_model.tick(4);
    t_both();
    t_bytes();
    t_abort();
    t_auto();
    conclude();
  end
endmodule : test_dual_dac_serial_load_port
